/* File: tb_tws_serial_port.sv */
// Self-checking testbench of the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module tb_tws_serial_port;
  import tws_pkg::*;
  logic        clk, rst_n, rd_s, wr_s, tx_wr, ss_n, load, gen, pol, pha, lsb;
  logic [15:0] addr;
  logic [7:0]  wdata, tx_data, peer_tx;
  wire  logic [7:0] rdata, rx_out, peer_rx;
  wire  logic  busy, irq, sck_o, sck_oe, so, so_oe, peer_sck, si, sck;
  int          fail_count, checked;

  assign sck = sck_oe ? sck_o : peer_sck;
  tws_serial_port u_tws_serial_port (.sys_clk_in(clk), .reset_n_in(rst_n),
    .reg_addr_in(addr), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .tx_wr_in(tx_wr), .tx_data_in(tx_data), .rx_data_out(rx_out),
    .busy_out(busy), .transfer_done_irq_out(irq), .serial_clock_pin_in(sck),
    .serial_clock_pin_out(sck_o), .serial_clock_pin_oe_out(sck_oe),
    .serial_data_out_pin_out(so), .serial_data_out_pin_oe_out(so_oe),
    .serial_data_in_pin_in(si), .slave_select_n_pin_in(ss_n));
  tws_peer_model u_tws_peer_model (.sys_clk_in(clk), .reset_n_in(rst_n), .pol_in(pol),
    .pha_in(pha), .lsb_in(lsb), .load_in(load), .gen_in(gen), .tx_in(peer_tx),
    .sck_in(sck), .so_in(so), .sck_out(peer_sck), .si_out(si), .rx_out(peer_rx));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // Register write and read
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) {wr_s, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk) {rd_s, addr} <= {1'b1, a};
    @(posedge clk) rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Reset values, fixed-zero bits and an unmapped place
  task automatic reg_test();
    logic [7:0]  d;
    logic [15:0] a [3] = '{TWS_ADDR_ASYNC_MODE, TWS_ADDR_SYNC_MODE, TWS_ADDR_PRESCALE};
    logic [7:0]  mk [3] = '{TWS_MASK_ASYNC_MODE, TWS_MASK_SYNC_MODE, TWS_MASK_PRESCALE};
    for (int k = 0; k < 3; k++) begin
      rd(a[k], d);
      chk(d, 8'h00, "reset value");
      wr(a[k], 8'hff);
      rd(a[k], d);
      chk(d, mk[k], "fixed bits");
    end
    wr(16'hff71, 8'h5a);
    rd(16'hff71, d);
    chk(d, 8'h00, "unmapped read");
    wr(TWS_ADDR_SYNC_MODE, 8'h00);
    wr(TWS_ADDR_ASYNC_MODE, 8'h00);
  endtask : reg_test

  // One frame in the mode m; master measures each clock half period
  task automatic xfer(input logic [7:0] m, input logic [2:0] s, input logic [7:0] td,
                      input logic [7:0] tp);
    int   n;
    int   last;
    logic prev;
    logic sl;
    {pol, lsb, pha, sl} = {m[0], m[2], m[3], ~m[1]};
    wr(TWS_ADDR_PRESCALE, {1'b0, s, 4'h0});
    wr(TWS_ADDR_SYNC_MODE, m);
    repeat (2) @(posedge clk);
    {peer_tx, load, tx_wr, tx_data} <= {tp, 1'b1, 1'b1, td};
    @(posedge clk) {load, tx_wr, gen} <= {1'b0, 1'b0, sl};
    @(posedge clk) gen <= 1'b0;
    #1 prev = sck;
    {n, last} = {32'd0, 32'd0};
    while (n < 5000 && irq !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (!sl && sck !== prev) begin
        if (last != 0) chk(n - last, 32'h2 << s, "half period");
        last = n;
      end
      prev = sck;
    end
    chk(irq, 1'b1, "completion");
    chk(busy, 1'b0, "busy at end");
    chk(rx_out, tp, "byte received");
    chk(sck, !pol, "clock idle");
    chk(sck_oe, !sl, "clock source");
    @(posedge clk);
    #1 chk(so, (m[6] && pha != pol) ? 1'b1 : (lsb ? td[7] : td[0]), "line after frame");
    chk(peer_rx, td, "byte sent");
    if (m[6]) begin
      @(posedge clk) ss_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(so_oe, 1'b0, "deselected output");
      @(posedge clk) ss_n <= 1'b0;
    end
  endtask : xfer

  // Writes while disabled, and enabling after the write
  task automatic off_test();
    wr(TWS_ADDR_SYNC_MODE, 8'h02);
    @(posedge clk) {tx_wr, tx_data} <= {1'b1, 8'h3c};
    @(posedge clk) tx_wr <= 1'b0;
    @(posedge clk);
    #1 chk(busy, 1'b0, "disabled start");
    chk(sck_oe, 1'b0, "disabled clock");
    wr(TWS_ADDR_SYNC_MODE, 8'h82);
    repeat (3) @(posedge clk);
    #1 chk(busy, 1'b0, "late enable");
  endtask : off_test

  // Verdict and end of run
  task automatic conclude();
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog
  initial begin
    #2000000;
    fail_count++;
    conclude();
  end

  // Main sequence
  initial begin
    {rst_n, rd_s, wr_s, tx_wr, ss_n, load, gen, pol, pha, lsb} = '0;
    {addr, wdata, tx_data, peer_tx} = '0;
    {fail_count, checked} = {32'd0, 32'd0};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    reg_test();
    for (int i = 0; i < 8; i++)
      xfer({4'h8, i[1], i[2], 1'b1, i[0]}, i[2:0], 8'h4b ^ 8'(i), 8'hd2 ^ 8'(i << 4));
    off_test();
    for (int i = 0; i < 4; i++)
      xfer({4'hc, i[1], i[0] ^ i[1], 1'b0, i[0]}, 3'h0, 8'h61 ^ 8'(i), 8'h1e ^ 8'(i << 5));
    conclude();
  end
endmodule : tb_tws_serial_port
`default_nettype wire

/* File: tws_baud_gen.sv */
// Prescaler that marks each half period of the generated serial clock
`timescale 1ns/1ps
`default_nettype none
module tws_baud_gen
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  // Control
  input  wire logic       run_in,
  input  wire logic [2:0] sel_in,
  // Half period marker
  output logic            half_tick_out
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [8:0] span;

  // Count to 2^(sel+1) system clocks per half period
  always_comb begin
    span          = TWS_HALF_BASE << sel_in;
    half_tick_out = run_in && (cnt_q == 8'(span - 9'h001));
    if (!run_in || half_tick_out) begin
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // Counter register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : tws_baud_gen
`default_nettype wire

/* File: tws_peer_model.sv */
// Behavioural serial peer on the far side of the three-wire port
`timescale 1ns/1ps
`default_nettype none
module tws_peer_model
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  // Frame settings
  input  wire logic       pol_in,
  input  wire logic       pha_in,
  input  wire logic       lsb_in,
  // Frame start and byte to send
  input  wire logic       load_in,
  input  wire logic       gen_in,
  input  wire logic [7:0] tx_in,
  // Pins
  input  wire logic       sck_in,
  input  wire logic       so_in,
  output logic            sck_out,
  output logic            si_out,
  // Byte received
  output logic      [7:0] rx_out
);
  logic       sck_q;
  logic       act_q;
  logic       first_q;
  logic [3:0] idx_q;
  logic [3:0] cnt_q;
  logic [4:0] edg_q;
  logic [1:0] div_q;

  // Bit of the byte in transfer order
  function automatic logic pick(input logic [7:0] b, input logic [3:0] i);
    return lsb_in ? b[i[2:0]] : b[3'h7 - i[2:0]];
  endfunction : pick

  // Shift on pin edges; wander the data line between frames; make a slave clock
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {sck_q, act_q, first_q, si_out, idx_q, cnt_q, edg_q, div_q, rx_out} <= '0;
      sck_out <= 1'b1;
    end else begin
      sck_q <= sck_in;
      if (!act_q) si_out <= ~si_out; // Released line never holds
      if (load_in) begin
        {act_q, first_q} <= 2'b11;
        idx_q            <= 4'h0;
        cnt_q            <= 4'h0;
        si_out           <= pick(tx_in, 4'h0);
      end else if (act_q && sck_in != sck_q) begin
        if (sck_in == pha_in) begin
          first_q <= 1'b0;
          if (!(first_q && pha_in == pol_in)) begin
            idx_q  <= idx_q + 4'h1;
            si_out <= pick(tx_in, idx_q + 4'h1);
          end
        end else begin
          rx_out <= lsb_in ? {so_in, rx_out[7:1]} : {rx_out[6:0], so_in};
          cnt_q  <= cnt_q + 4'h1;
          if (cnt_q == 4'h7) act_q <= 1'b0;
        end
      end
      if (gen_in) begin
        edg_q <= 5'h10;
        div_q <= 2'h0;
      end else if (edg_q != 5'h00) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
          sck_out <= ~sck_out;
          edg_q   <= edg_q - 5'h01;
        end
      end else sck_out <= ~pol_in; // Clock stands at idle outside frames
    end
  end
endmodule : tws_peer_model
`default_nettype wire

/* File: tws_pkg.sv */
// Shared constants and types for the three-wire synchronous serial port
package tws_pkg;

  // Register addresses
  localparam logic [15:0] TWS_ADDR_ASYNC_MODE = 16'hff70;
  localparam logic [15:0] TWS_ADDR_SYNC_MODE  = 16'hff72;
  localparam logic [15:0] TWS_ADDR_PRESCALE   = 16'hff73;

  // Reset values
  localparam logic [7:0] TWS_RST_ASYNC_MODE = 8'h00;
  localparam logic [7:0] TWS_RST_SYNC_MODE  = 8'h00;
  localparam logic [7:0] TWS_RST_PRESCALE   = 8'h00;

  // Writable bits; fixed-zero bits read back as zero
  localparam logic [7:0] TWS_MASK_ASYNC_MODE = 8'hfc;
  localparam logic [7:0] TWS_MASK_SYNC_MODE  = 8'hcf;
  localparam logic [7:0] TWS_MASK_PRESCALE   = 8'hf0;

  // Prescale select field position
  localparam int TWS_PRESCALE_SEL_LSB = 4;

  // Frame geometry: eight bits, sixteen serial clock edges
  localparam logic [3:0] TWS_FRAME_BITS  = 4'h8;
  localparam logic [4:0] TWS_LAST_EDGE   = 5'h0f;
  // Half period of the generated clock is 2 << select system clocks
  localparam logic [8:0] TWS_HALF_BASE   = 9'h002;

  // Synchronous mode register layout
  typedef struct packed {
    logic       enable;
    logic       slave_sel_use;
    logic [1:0] fixed_zero;
    logic       data_phase;
    logic       bit_order;
    logic       clock_source;
    logic       clock_polarity;
  } tws_mode_s;

  // Transfer state
  typedef enum logic {TWS_IDLE, TWS_XFER} tws_state_e;

endpackage : tws_pkg

/* File: tws_serial_port.sv */
// Three-wire synchronous serial port: registers, shifter and pin control
//
// What this block does
// - Serial function runs only while the mode enable bit is set.
// - With select in use, slave transfers only while select low; output floats when high.
// - Select configurations ending high drive output high after last bit until select rises.
// - Data phase picks launch edge: 0 falling edge, 1 rising edge.
// - Bit order 0 shifts most significant bit first, 1 least significant first.
// - Clock source 0 takes pin clock as slave, 1 drives it as master.
// - Clock polarity 0 idles clock high, 1 idles clock low.
// - Prescale select codes 0 to 7 mark half periods at system clock over 2^(n+1).
// - Master serial clock is system clock divided by 2^(n+2).
// - Frames are eight bits, one bit each way per serial clock.
// - Shift on launch edge through output latch, capture input on other edge.
// - After eight bits shifting stops and completion interrupt is raised.
// - Outside transfers, except during that high hold, the data output keeps the last bit sent.
// - Reset clears sync mode, async mode and prescale registers.
// - Transmit write starts a transfer only if enabled and clock idle.
`timescale 1ns/1ps
`default_nettype none
module tws_serial_port
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // Register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  // Data port
  input  wire logic        tx_wr_in,
  input  wire logic [7:0]  tx_data_in,
  output logic      [7:0]  rx_data_out,
  output logic             busy_out,
  output logic             transfer_done_irq_out,
  // Serial pins
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe_out,
  output logic             serial_data_out_pin_out,
  output logic             serial_data_out_pin_oe_out,
  input  wire logic        serial_data_in_pin_in,
  input  wire logic        slave_select_n_pin_in
);

  // Registers and their next values
  logic [7:0] async_q, async_d, sync_q, sync_d, presc_q, presc_d, rdata_q, rdata_d;
  tws_state_e state_q, state_d;
  logic [7:0] tx_q, tx_d, rx_q, rx_d, rxbuf_q, rxbuf_d;
  logic [4:0] edge_cnt_q, edge_cnt_d;
  logic [3:0] launch_cnt_q, launch_cnt_d, out_idx;
  logic       do_q, do_d, sck_q, sck_d, sck_prev_q, ss_prev_q, hold_q, hold_d, irq_q, irq_d;
  // Decoded control
  tws_mode_s  mode;
  logic       tick, master, idle_lvl, selected, launch_first, start;
  logic       edge_ev, new_lvl, launch_ev, sample_ev, done, ss_rise;

  // Pick a bit of a byte in the configured order
  function automatic logic pick_bit(input logic [7:0] d, input logic [2:0] i,
                                    input logic lsb_first);
    return lsb_first ? d[i] : d[3'h7 - i];
  endfunction : pick_bit

  // Master clock prescaler
  tws_baud_gen u_baud (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .run_in        (state_q == TWS_XFER && master),
    .sel_in        (presc_q[TWS_PRESCALE_SEL_LSB +: 3]),
    .half_tick_out (tick)
  );

  // Mode decode and edge events
  always_comb begin
    mode         = tws_mode_s'(sync_q);
    master       = mode.clock_source;
    idle_lvl     = ~mode.clock_polarity;
    selected     = !mode.slave_sel_use || !slave_select_n_pin_in;
    launch_first = (mode.data_phase == mode.clock_polarity);
    ss_rise      = slave_select_n_pin_in && !ss_prev_q;
    start        = tx_wr_in && mode.enable && state_q == TWS_IDLE
                   && (master || serial_clock_pin_in == idle_lvl);
    if (master) begin
      edge_ev = tick && state_q == TWS_XFER;
      new_lvl = ~sck_q;
    end else begin
      edge_ev = state_q == TWS_XFER && selected && serial_clock_pin_in != sck_prev_q;
      new_lvl = serial_clock_pin_in;
    end
    launch_ev = edge_ev && (new_lvl == mode.data_phase);
    sample_ev = edge_ev && !launch_ev;
    done      = edge_ev && edge_cnt_q == TWS_LAST_EDGE;
    out_idx   = launch_first ? launch_cnt_q : launch_cnt_q + 4'h1;
  end

  // Register file writes and registered reads
  always_comb begin
    async_d = async_q;
    sync_d  = sync_q;
    presc_d = presc_q;
    rdata_d = rdata_q;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        TWS_ADDR_ASYNC_MODE: async_d = reg_wdata_in & TWS_MASK_ASYNC_MODE;
        TWS_ADDR_SYNC_MODE:  sync_d  = reg_wdata_in & TWS_MASK_SYNC_MODE;
        TWS_ADDR_PRESCALE:   presc_d = reg_wdata_in & TWS_MASK_PRESCALE;
        default:             ;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        TWS_ADDR_ASYNC_MODE: rdata_d = async_q;
        TWS_ADDR_SYNC_MODE:  rdata_d = sync_q;
        TWS_ADDR_PRESCALE:   rdata_d = presc_q;
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      async_q <= TWS_RST_ASYNC_MODE;
      sync_q  <= TWS_RST_SYNC_MODE;
      presc_q <= TWS_RST_PRESCALE;
      rdata_q <= 8'h00;
    end else begin
      async_q <= async_d;
      sync_q  <= sync_d;
      presc_q <= presc_d;
      rdata_q <= rdata_d;
    end
  end

  // Transfer sequencing and shifting
  always_comb begin
    state_d      = state_q;
    tx_d         = tx_q;
    rx_d         = rx_q;
    rxbuf_d      = rxbuf_q;
    edge_cnt_d   = edge_cnt_q;
    launch_cnt_d = launch_cnt_q;
    do_d         = do_q;
    sck_d        = sck_q;
    hold_d       = hold_q && !ss_rise;
    irq_d        = 1'b0;
    if (!mode.enable) begin
      state_d      = TWS_IDLE;
      edge_cnt_d   = 5'h00;
      launch_cnt_d = 4'h0;
      sck_d        = idle_lvl;
      hold_d       = 1'b0;
    end else if (state_q == TWS_IDLE) begin
      sck_d = idle_lvl;
      if (start) begin
        state_d      = TWS_XFER;
        tx_d         = tx_data_in;
        edge_cnt_d   = 5'h00;
        launch_cnt_d = 4'h0;
        hold_d       = 1'b0;
        if (!launch_first) begin
          do_d = pick_bit(tx_data_in, 3'h0, mode.bit_order);
        end
      end
    end else if (edge_ev) begin
      sck_d      = new_lvl;
      edge_cnt_d = edge_cnt_q + 5'h01;
      if (launch_ev) begin
        launch_cnt_d = launch_cnt_q + 4'h1;
        if (out_idx < TWS_FRAME_BITS) begin
          do_d = pick_bit(tx_q, out_idx[2:0], mode.bit_order);
        end
      end else begin
        rx_d = mode.bit_order ? {serial_data_in_pin_in, rx_q[7:1]}
                              : {rx_q[6:0], serial_data_in_pin_in};
      end
      if (done) begin
        state_d    = TWS_IDLE;
        edge_cnt_d = 5'h00;
        rxbuf_d    = rx_d;
        irq_d      = 1'b1;
        hold_d     = mode.slave_sel_use && !launch_first;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q      <= TWS_IDLE;
      tx_q         <= 8'h00;
      rx_q         <= 8'h00;
      rxbuf_q      <= 8'h00;
      edge_cnt_q   <= 5'h00;
      launch_cnt_q <= 4'h0;
      do_q         <= 1'b0;
      sck_q        <= 1'b1;
      hold_q       <= 1'b0;
      irq_q        <= 1'b0;
      sck_prev_q   <= 1'b1;
      ss_prev_q    <= 1'b1;
    end else begin
      state_q      <= state_d;
      tx_q         <= tx_d;
      rx_q         <= rx_d;
      rxbuf_q      <= rxbuf_d;
      edge_cnt_q   <= edge_cnt_d;
      launch_cnt_q <= launch_cnt_d;
      do_q         <= do_d;
      sck_q        <= sck_d;
      hold_q       <= hold_d;
      irq_q        <= irq_d;
      sck_prev_q   <= serial_clock_pin_in;
      ss_prev_q    <= slave_select_n_pin_in;
    end
  end

  // Outputs
  assign reg_rdata_out              = rdata_q;
  assign rx_data_out                = rxbuf_q;
  assign busy_out                   = state_q == TWS_XFER;
  assign transfer_done_irq_out      = irq_q;
  assign serial_clock_pin_out       = sck_q;
  assign serial_clock_pin_oe_out    = mode.enable && master;
  assign serial_data_out_pin_out    = hold_q ? 1'b1 : do_q;
  assign serial_data_out_pin_oe_out = mode.enable && selected;

  // Helper: cycles since the last master half-period marker, and its expected span
  logic [8:0] gap_q;
  logic [8:0] span_chk;
  assign span_chk = TWS_HALF_BASE << presc_q[TWS_PRESCALE_SEL_LSB +: 3];
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap_q <= 9'h000;
    end else if (tick || state_q != TWS_XFER) begin
      gap_q <= 9'h000;
    end else begin
      gap_q <= gap_q + 9'h001;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence seq_done_pulse;
    transfer_done_irq_out ##1 !transfer_done_irq_out;
  endsequence

  sequence seq_idle_two;
    (state_q == TWS_IDLE && $stable(sync_q)) [*2];
  endsequence

  AST_DISABLED_IDLE: assert property (!mode.enable |=> state_q == TWS_IDLE)
    else $error("transfer active while disabled");
  AST_SELECT_FLOAT: assert property (mode.slave_sel_use && slave_select_n_pin_in
    |-> !serial_data_out_pin_oe_out)
    else $error("data output driven while deselected");
  AST_END_HIGH: assert property (done && mode.slave_sel_use && !launch_first && !ss_rise
    |=> serial_data_out_pin_out)
    else $error("data output not high after frame");
  AST_LAUNCH_ONLY: assert property ($changed(do_q) |-> $past(launch_ev) || $past(start))
    else $error("output bit changed off launch edge");
  AST_FIRST_MSB: assert property (start && !launch_first && !mode.bit_order
    |=> do_q == $past(tx_data_in[7]))
    else $error("first bit not most significant");
  AST_SLAVE_NO_CLOCK: assert property (!mode.clock_source |-> !serial_clock_pin_oe_out)
    else $error("clock driven in slave mode");
  AST_IDLE_LEVEL: assert property (seq_idle_two |-> sck_q == ~mode.clock_polarity)
    else $error("clock not at idle level");
  AST_HALF_PERIOD: assert property (tick |-> gap_q == 9'(span_chk - 9'h001))
    else $error("master half period wrong");
  AST_CAPTURE: assert property (sample_ev && !mode.bit_order && !done
    |=> rx_q[0] == $past(serial_data_in_pin_in))
    else $error("input bit not captured");
  AST_DONE_IRQ: assert property (done && mode.enable |=> state_q == TWS_IDLE ##0 seq_done_pulse)
    else $error("completion pulse missing");
  AST_HOLD_LAST: assert property (state_q == TWS_IDLE && !start |=> $stable(do_q))
    else $error("idle output changed");
  AST_START_GATE: assert property (tx_wr_in && !mode.enable |=> state_q == TWS_IDLE)
    else $error("transfer started while disabled");
  AST_COUNT_CLEAR: assert property (!mode.enable |=> edge_cnt_q == 5'h00)
    else $error("bit counter not cleared");

endmodule : tws_serial_port
`default_nettype wire
